//--- rtl/iwdt_pkg.sv
// Constants, register map and types of the independent watchdog
// Operation
// - Counter and prescaler advance only on edges of the internal low-speed oscillator
// - The key field is write-only and always reads back as zero
// - Counter reaching zero without reload requests a system reset
// - Unlock word in the key field lifts write protection
// - Start word starts counting; hardware watchdog option runs without it
// - Read-only run bit 31 shows 1 while running, resets to 0
// - Read-only protect bit 30 shows 1 while protected, resets to 1
// - Protected stop-enable bit 29 turns the stop switch on, resets to 0
// - Read-only update flag bit 15 shows a configuration update occurred
// - Protected 3-bit divider select divides oscillator by 4 up to 512
// - Protected 12-bit reload value, reset all ones, loaded on reload word
// - Counter counts down from reload value, readable, resets to all ones
// - Timeout period follows from reload value and divider selection
`default_nettype none
package iwdt_pkg;
  localparam logic [31:0] ADDR_KEY    = 32'h40001000;
  localparam logic [31:0] ADDR_CFG    = 32'h40001004;
  localparam logic [31:0] ADDR_STAT   = 32'h40001008;
  localparam logic [31:0] ADDR_MASK   = 32'h4000100c;
  localparam logic [15:0] KEY_RELOAD  = 16'haaaa;
  localparam logic [15:0] KEY_UNLOCK  = 16'h5555;
  localparam logic [15:0] KEY_START   = 16'hcccc;
  localparam int          RUN_BIT     = 31;
  localparam int          PROT_BIT    = 30;
  localparam int          STOP_BIT    = 29;
  localparam int          CNT_MSB     = 27;
  localparam int          CNT_LSB     = 16;
  localparam int          UPD_BIT     = 15;
  localparam int          DIV_MSB     = 14;
  localparam int          DIV_LSB     = 12;
  localparam int          RLD_MSB     = 11;
  localparam int          RLD_LSB     = 0;
  localparam int          CNT_W       = 12;
  localparam int          DIV_W       = 3;
  localparam int          PRE_W       = 9;
  localparam logic [11:0] CNT_RST     = 12'hfff;
  localparam logic [11:0] RLD_RST     = 12'hfff;
  localparam logic [2:0]  DIV_RST     = 3'h0;
  localparam logic [8:0]  PRE_BASE    = 9'h004;
  localparam int          EV_W        = 3;
  localparam int          EV_TIMEOUT  = 0;
  localparam int          EV_RELOAD   = 1;
  localparam int          EV_BADKEY   = 2;
  localparam logic [2:0]  EV_RST      = 3'h0;
  localparam int          BITE_CYCLES = 16;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ  = 2'h3;
  localparam logic [31:0] ZERO_WORD   = 32'h00000000;

  typedef enum logic [2:0] {
    IWDT_IDLE = 3'b001,
    IWDT_RUN  = 3'b010,
    IWDT_BITE = 3'b100
  } iwdt_state_e;
endpackage : iwdt_pkg
`default_nettype wire

//--- rtl/iwdt_top.sv
// Independent watchdog with AHB-Lite register slave and interrupt
//
// Implementation choice: the AHB-Lite interface to the registers.
`default_nettype none
module iwdt_top #(
  parameter int BITE_LEN = iwdt_pkg::BITE_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output var  logic        hreadyout_o,
  output var  logic        hresp_o,
  output var  logic [31:0] hrdata_o,
  input  wire logic        lsi_clk_i,
  input  wire logic        hw_mode_i,
  input  wire logic        core_halt_i,
  output var  logic        sys_reset_o,
  output var  logic        irq_o
);
  // Bus data phase
  logic                      dp_wr;
  logic [31:0]               dp_addr;
  logic                      wr_key;
  logic                      wr_cfg;
  logic                      wr_stat;
  logic                      wr_mask;
  logic [15:0]               key_word;
  logic                      cmd_reload;
  logic                      cmd_unlock;
  logic                      cmd_start;
  logic                      cmd_bad;
  logic                      addr_take;
  logic [31:0]               rd_mux;

  // Watchdog state
  iwdt_pkg::iwdt_state_e     state;
  iwdt_pkg::iwdt_state_e     next_state;
  logic                      protect;
  logic                      stop_en;
  logic                      upd_flag;
  logic [iwdt_pkg::DIV_W-1:0] div_sel;
  logic [iwdt_pkg::CNT_W-1:0] reload_value;
  logic [iwdt_pkg::CNT_W-1:0] count;
  logic [iwdt_pkg::PRE_W-1:0] pre_cnt;
  logic                      lsi_q;
  logic                      lsi_rise;
  logic                      frozen;
  logic                      counting;
  logic                      tick;
  logic                      expire;
  logic [7:0]                bite_cnt;
  logic                      bite_done;

  // Interrupt state
  logic [iwdt_pkg::EV_W-1:0] status;
  logic [iwdt_pkg::EV_W-1:0] mask;
  logic [iwdt_pkg::EV_W-1:0] events;
  logic [iwdt_pkg::EV_W-1:0] next_status;

  // Terminal value of the prescaler for a divider code
  function automatic logic [iwdt_pkg::PRE_W-1:0] pre_limit(
    input logic [iwdt_pkg::DIV_W-1:0] sel
  );
    logic [iwdt_pkg::PRE_W:0] div;
    div       = {1'b0, iwdt_pkg::PRE_BASE} << sel;
    pre_limit = iwdt_pkg::PRE_W'(div - 10'h001);
  endfunction : pre_limit

  // Address match on a word-aligned register
  function automatic logic hit(
    input logic [31:0] addr,
    input logic [31:0] reg_addr
  );
    hit = (addr == reg_addr);
  endfunction : hit

  // Address phase capture
  assign addr_take = hsel_i & hready_i &
                     ((htrans_i == iwdt_pkg::HTRANS_NSEQ) ||
                      (htrans_i == iwdt_pkg::HTRANS_SEQ));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dp_wr   <= 1'b0;
      dp_addr <= iwdt_pkg::ZERO_WORD;
    end else if (hready_i) begin
      dp_wr   <= addr_take & hwrite_i;
      dp_addr <= haddr_i;
    end
  end

  // Zero wait state slave, always OKAY
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // Read multiplexer
  always_comb begin
    rd_mux = iwdt_pkg::ZERO_WORD;
    if (hit(haddr_i, iwdt_pkg::ADDR_KEY)) begin
      rd_mux = iwdt_pkg::ZERO_WORD;
    end else if (hit(haddr_i, iwdt_pkg::ADDR_CFG)) begin
      rd_mux[iwdt_pkg::RUN_BIT]                  = (state != iwdt_pkg::IWDT_IDLE);
      rd_mux[iwdt_pkg::PROT_BIT]                 = protect;
      rd_mux[iwdt_pkg::STOP_BIT]                 = stop_en;
      rd_mux[iwdt_pkg::CNT_MSB:iwdt_pkg::CNT_LSB] = count;
      rd_mux[iwdt_pkg::UPD_BIT]                  = upd_flag;
      rd_mux[iwdt_pkg::DIV_MSB:iwdt_pkg::DIV_LSB] = div_sel;
      rd_mux[iwdt_pkg::RLD_MSB:iwdt_pkg::RLD_LSB] = reload_value;
    end else if (hit(haddr_i, iwdt_pkg::ADDR_STAT)) begin
      rd_mux[iwdt_pkg::EV_W-1:0] = status;
    end else if (hit(haddr_i, iwdt_pkg::ADDR_MASK)) begin
      rd_mux[iwdt_pkg::EV_W-1:0] = mask;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hrdata_o <= iwdt_pkg::ZERO_WORD;
    end else if (hready_i) begin
      hrdata_o <= (addr_take & ~hwrite_i) ? rd_mux : iwdt_pkg::ZERO_WORD;
    end
  end

  // Write decode in the data phase
  assign wr_key     = dp_wr & hit(dp_addr, iwdt_pkg::ADDR_KEY);
  assign wr_cfg     = dp_wr & hit(dp_addr, iwdt_pkg::ADDR_CFG);
  assign wr_stat    = dp_wr & hit(dp_addr, iwdt_pkg::ADDR_STAT);
  assign wr_mask    = dp_wr & hit(dp_addr, iwdt_pkg::ADDR_MASK);
  assign key_word   = hwdata_i[15:0];
  assign cmd_reload = wr_key & (key_word == iwdt_pkg::KEY_RELOAD);
  assign cmd_unlock = wr_key & (key_word == iwdt_pkg::KEY_UNLOCK);
  assign cmd_start  = wr_key & (key_word == iwdt_pkg::KEY_START);
  assign cmd_bad    = wr_key & ~cmd_reload & ~cmd_unlock & ~cmd_start;

  // Write protection
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      protect <= 1'b1;
    end else if (cmd_unlock) begin
      protect <= 1'b0;
    end else if (wr_key) begin
      protect <= 1'b1;
    end
  end

  // Protected configuration fields
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stop_en      <= 1'b0;
      div_sel      <= iwdt_pkg::DIV_RST;
      reload_value <= iwdt_pkg::RLD_RST;
    end else if (wr_cfg && !protect) begin
      stop_en      <= hwdata_i[iwdt_pkg::STOP_BIT];
      div_sel      <= hwdata_i[iwdt_pkg::DIV_MSB:iwdt_pkg::DIV_LSB];
      reload_value <= hwdata_i[iwdt_pkg::RLD_MSB:iwdt_pkg::RLD_LSB];
    end
  end

  // Update flag, held until the next counter step, cleared while idle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      upd_flag <= 1'b0;
    end else if (wr_cfg && !protect) begin
      upd_flag <= 1'b1;
    end else if (tick || state == iwdt_pkg::IWDT_IDLE) begin
      upd_flag <= 1'b0;
    end
  end

  // Oscillator edge detect and prescaler
  assign lsi_rise = lsi_clk_i & ~lsi_q;
  assign frozen   = stop_en & core_halt_i;
  assign counting = (state == iwdt_pkg::IWDT_RUN) & ~frozen;
  assign tick     = counting & lsi_rise & (pre_cnt == pre_limit(div_sel));
  assign expire   = tick & (count == '0);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lsi_q <= 1'b0;
    end else begin
      lsi_q <= lsi_clk_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pre_cnt <= '0;
    end else if (cmd_reload || state != iwdt_pkg::IWDT_RUN) begin
      pre_cnt <= '0;
    end else if (tick) begin
      pre_cnt <= '0;
    end else if (counting && lsi_rise) begin
      pre_cnt <= pre_cnt + 9'h001;
    end
  end

  // Down-counter
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      count <= iwdt_pkg::CNT_RST;
    end else if (cmd_reload || expire) begin
      count <= reload_value;
    end else if (tick) begin
      count <= count - 12'h001;
    end
  end

  // Run state machine
  assign bite_done = (bite_cnt == 8'(BITE_LEN - 1));

  always_comb begin
    next_state = state;
    unique case (state)
      iwdt_pkg::IWDT_IDLE: begin
        if (cmd_start || hw_mode_i) begin
          next_state = iwdt_pkg::IWDT_RUN;
        end
      end
      iwdt_pkg::IWDT_RUN: begin
        if (expire) begin
          next_state = iwdt_pkg::IWDT_BITE;
        end
      end
      iwdt_pkg::IWDT_BITE: begin
        if (bite_done) begin
          next_state = iwdt_pkg::IWDT_RUN;
        end
      end
      default: begin
        next_state = iwdt_pkg::IWDT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state <= iwdt_pkg::IWDT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bite_cnt <= '0;
    end else if (state == iwdt_pkg::IWDT_BITE) begin
      bite_cnt <= bite_cnt + 8'h01;
    end else begin
      bite_cnt <= '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sys_reset_o <= 1'b0;
    end else begin
      sys_reset_o <= (next_state == iwdt_pkg::IWDT_BITE);
    end
  end

  // Sticky status, write one to clear, set wins
  always_comb begin
    events                       = '0;
    events[iwdt_pkg::EV_TIMEOUT] = expire;
    events[iwdt_pkg::EV_RELOAD]  = cmd_reload;
    events[iwdt_pkg::EV_BADKEY]  = cmd_bad;
    next_status                  = status;
    if (wr_stat) begin
      next_status = status & ~hwdata_i[iwdt_pkg::EV_W-1:0];
    end
    next_status = next_status | events;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      status <= iwdt_pkg::EV_RST;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mask <= iwdt_pkg::EV_RST;
    end else if (wr_mask) begin
      mask <= hwdata_i[iwdt_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_status & mask);
    end
  end

endmodule : iwdt_top
`default_nettype wire

//--- tb/iwdt_properties.sv
// Concurrent checks on the watchdog's ports
`default_nettype none
module iwdt_properties #(
  parameter int BITE_LEN = 16
) (
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic        lsi_clk_i,
  input wire logic        sys_reset_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int        bite_cnt;
  wire logic rd_take;
  assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  always_ff @(posedge mclk_i) begin
    if (reset_i || !sys_reset_o) begin
      bite_cnt <= 0;
    end else begin
      bite_cnt <= bite_cnt + 1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence s_release;
    $fell(reset_i);
  endsequence
  sequence s_key_read;
    rd_take && haddr_i == iwdt_pkg::ADDR_KEY;
  endsequence
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("error response seen");
  a_ready_up: assert property (s_release |-> !hreadyout_o ##1 hreadyout_o)
    else $error("ready not raised after reset");
  a_ready_stays: assert property (!$past(reset_i) |-> hreadyout_o)
    else $error("wait state inserted");
  a_reset_quiet: assert property (s_release |-> !sys_reset_o && !irq_o && hrdata_o == 32'h0)
    else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (!$past(rd_take) |-> hrdata_o == 32'h0)
    else $error("read data outside data phase");
  a_key_zero: assert property (s_key_read |=> hrdata_o == 32'h0)
    else $error("key field read nonzero");
  a_bite_length: assert property ($fell(sys_reset_o) |-> bite_cnt == BITE_LEN)
    else $error("system reset pulse length wrong");
  a_bite_from_lsi: assert property ($rose(sys_reset_o) |->
    $past(lsi_clk_i, 1) || $past(lsi_clk_i, 2) || $past(lsi_clk_i, 3))
    else $error("timeout without oscillator edge");
endmodule : iwdt_properties
bind iwdt_top iwdt_properties #(.BITE_LEN(BITE_LEN)) u_props (.mclk_i, .reset_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .lsi_clk_i,
  .sys_reset_o, .irq_o);
`default_nettype wire

//--- tb/iwdt_top_bench.sv
// Self-checking bench for the independent watchdog
`default_nettype none
module iwdt_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i      = 1'b0;
  logic        reset_i     = 1'b1;
  logic        hsel_i      = 1'b0;
  logic [31:0] haddr_i     = 32'h0;
  logic [1:0]  htrans_i    = 2'h0;
  logic        hwrite_i    = 1'b0;
  logic [31:0] hwdata_i    = 32'h0;
  logic        lsi_clk_i   = 1'b0;
  logic        hw_mode_i   = 1'b0;
  logic        core_halt_i = 1'b0;
  wire logic   hready;
  wire logic   sys_reset_o;
  wire logic   irq_o;
  wire logic [31:0] hrdata;
  logic [31:0] r;
  int          errors = 0;
  int          total_checks = 0;
  int          rl;
  int          dv;
  int          per;
  always #50 mclk_i = ~mclk_i;
  iwdt_top #(.BITE_LEN(2)) dut (.mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hready), .hreadyout_o(hready), .hresp_o(),
    .hrdata_o(hrdata), .lsi_clk_i, .hw_mode_i, .core_halt_i, .sys_reset_o, .irq_o);
  task automatic summarize();
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    hwrite_i <= w;
    htrans_i <= iwdt_pkg::HTRANS_NSEQ;
    do @(posedge mclk_i); while (hready !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, $urandom);
    chk(nm, e, r & ~32'h00008000);
  endtask : rd
  task automatic internal_low_speed_oscillator(input int n);
    repeat (n) begin
      lsi_clk_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      lsi_clk_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
    end
  endtask : internal_low_speed_oscillator
  function automatic logic [31:0] cfg(input int run, input int prot, input int stp, int cnt);
    return {run[0], prot[0], stp[0], 1'b0, cnt[11:0], 1'b0, dv[2:0], rl[11:0]};
  endfunction : cfg
  initial begin
    void'($urandom(32'hddfd));
    rl = 'hfff;
    dv = 0;
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rd("key", iwdt_pkg::ADDR_KEY, 32'h0);
    rd("cfg reset", iwdt_pkg::ADDR_CFG, cfg(0, 1, 0, 'hfff));
    rd("unmapped", 32'h40001010, 32'h0);
    bus(1'b1, iwdt_pkg::ADDR_CFG, 32'h20003005);
    rd("cfg locked", iwdt_pkg::ADDR_CFG, cfg(0, 1, 0, 'hfff));
    bus(1'b1, iwdt_pkg::ADDR_KEY, {16'h0, iwdt_pkg::KEY_UNLOCK});
    rl = 1 + $urandom % 4;
    dv = $urandom % 8;
    per = 4 << dv;
    bus(1'b1, iwdt_pkg::ADDR_CFG, cfg(0, 0, 1, 0));
    rd("cfg open", iwdt_pkg::ADDR_CFG, cfg(0, 0, 1, 'hfff));
    bus(1'b1, iwdt_pkg::ADDR_KEY, {16'h0, iwdt_pkg::KEY_START});
    bus(1'b1, iwdt_pkg::ADDR_KEY, {16'h0, iwdt_pkg::KEY_RELOAD});
    rd("cfg run", iwdt_pkg::ADDR_CFG, cfg(1, 1, 1, rl));
    core_halt_i <= 1'b1;
    internal_low_speed_oscillator(6);
    rd("cfg frozen", iwdt_pkg::ADDR_CFG, cfg(1, 1, 1, rl));
    core_halt_i <= 1'b0;
    internal_low_speed_oscillator(rl * per);
    rd("count zero", iwdt_pkg::ADDR_CFG, cfg(1, 1, 1, 0));
    internal_low_speed_oscillator(per - 1);
    chk("early reset", 32'h0, {31'h0, sys_reset_o});
    lsi_clk_i <= 1'b1;
    for (int i = 0; i < 6 && sys_reset_o !== 1'b1; i++) @(posedge mclk_i);
    chk("timeout reset", 32'h1, {31'h0, sys_reset_o});
    lsi_clk_i <= 1'b0;
    bus(1'b1, iwdt_pkg::ADDR_KEY, 32'h00001234);
    rd("status", iwdt_pkg::ADDR_STAT, 32'h7);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    bus(1'b1, iwdt_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk("irq on", 32'h1, {31'h0, irq_o});
    bus(1'b1, iwdt_pkg::ADDR_STAT, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk("irq off", 32'h0, {31'h0, irq_o});
    rd("status clear", iwdt_pkg::ADDR_STAT, 32'h6);
    reset_i <= 1'b1;
    hw_mode_i <= 1'b1;
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rl = 'hfff;
    dv = 0;
    rd("hw mode", iwdt_pkg::ADDR_CFG, cfg(1, 1, 0, 'hfff));
    bus(1'b1, iwdt_pkg::ADDR_KEY, {16'h0, iwdt_pkg::KEY_UNLOCK});
    bus(1'b1, iwdt_pkg::ADDR_CFG, cfg(0, 0, 0, 0));
    bus(1'b0, iwdt_pkg::ADDR_CFG, 32'h0);
    chk("update set", 32'h1, {31'h0, r[iwdt_pkg::UPD_BIT]});
    internal_low_speed_oscillator(4);
    rd("cfg step", iwdt_pkg::ADDR_CFG, cfg(1, 0, 0, 'hffe));
    chk("update clear", 32'h0, {31'h0, r[iwdt_pkg::UPD_BIT]});
    summarize();
  end
  initial begin
    #3000000;
    errors++;
    summarize();
  end
endmodule : iwdt_top_bench
`default_nettype wire
